// ==== amd_decoder.sv ====
// Addressing mode engine: operand fetch, pointer fetch, address and length
//
// Overview of operation
// - Seventeen operand addressing modes in seven families are handled.
// - Long forms reach all 64 Kbyte, with more cycles; long direct and indexed also take more bytes.
// - Short forms start from a page-zero base and are faster; short direct and indexed are also shorter.
// - Read-modify-write instructions accept short forms only; long ones flag a fault.
// - Inherent instructions are one byte, two with the Y prebyte; no operand bytes.
// - Immediate takes one byte after the opcode as the operand value.
// - Short direct takes one address byte, range 00 to FF.
// - Long direct takes a two-byte address word, full space.
// - Indexed address is the unsigned sum of index and offset.
// - No-offset indexed adds no byte; Y index costs one extra byte.
// - Short indexed takes a one-byte offset, reaching 00 to 1FE.
// - Long indexed takes a two-byte offset, reaching the whole space.
// - Indirect reads the operand address from a page-zero pointer.
// - Short indirect fetches a one-byte pointer, address 00 to FF.
// - Long indirect fetches a two-byte pointer, full space.
// - Relative targets span PC-128 to PC+127, PC after the branch.
// - Short indirect indexed adds index to a one-byte pointer, 00 to 1FE.
// - Relative branch adds a signed byte from stream or memory.
module amd_decoder
  import amd_pkg::*;
(
  input logic clock,
  input logic nrst,
  input logic start,
  input amd_mode_t mode,
  input logic use_y,
  input logic rmw,
  input logic [15:0] opc_addr,
  input logic [7:0] idx_x,
  input logic [7:0] idx_y,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input logic [7:0] mem_rdata,
  input logic mem_ack,
  output logic busy,
  output logic done,
  output logic [15:0] ea,
  output logic ea_valid,
  output logic [7:0] operand,
  output logic operand_valid,
  output logic [15:0] target,
  output logic target_valid,
  output logic [15:0] next_pc,
  output logic [2:0] instr_len,
  output amd_family_t family,
  output logic short_form,
  output logic rmw_fault
);

  typedef enum logic [1:0] {
    ST_IDLE, ST_OPND, ST_PTR, ST_CALC
  } amd_state_t;

  // Control state
  amd_state_t state_r, state_nxt;
  amd_mode_t mode_r, mode_nxt;
  logic [1:0] nops_r, nops_nxt;
  logic [1:0] nptr_r, nptr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] opc_r, opc_nxt;
  logic [7:0] index_r, index_nxt;
  logic rmw_r, rmw_nxt;
  logic long_r, long_nxt;
  logic ind_r, ind_nxt;
  logic [2:0] len_r, len_nxt;
  amd_family_t fam_r, fam_nxt;

  // Fetched bytes
  logic [7:0] b0_r, b0_nxt;
  logic [7:0] b1_r, b1_nxt;
  logic [7:0] p0_r, p0_nxt;
  logic [7:0] p1_r, p1_nxt;

  // Result registers
  logic done_r, done_nxt;
  logic [15:0] ea_r, ea_nxt;
  logic ea_valid_r, ea_valid_nxt;
  logic [7:0] operand_r, operand_nxt;
  logic operand_valid_r, operand_valid_nxt;
  logic [15:0] target_r, target_nxt;
  logic target_valid_r, target_valid_nxt;
  logic [15:0] next_pc_r, next_pc_nxt;
  logic [2:0] instr_len_r, instr_len_nxt;
  amd_family_t family_r, family_nxt;
  logic short_r, short_nxt;
  logic rmw_fault_r, rmw_fault_nxt;

  // Decoder results for the incoming request
  logic [1:0] dec_opnd;
  logic [1:0] dec_ptr;
  logic dec_pre;
  logic [2:0] dec_len;
  logic dec_ind;
  logic dec_long;
  amd_family_t dec_family;

  // Adder operands and results
  logic [15:0] calc_base;
  logic calc_add_idx;
  logic [7:0] calc_disp;
  logic [15:0] calc_ea;
  logic [15:0] calc_target;
  logic [15:0] pc_after;

  amd_len_dec u_len (
    .mode(mode),
    .use_y(use_y),
    .opnd_bytes(dec_opnd),
    .ptr_bytes(dec_ptr),
    .pre_byte(dec_pre),
    .instr_len(dec_len),
    .indirect(dec_ind),
    .long_form(dec_long),
    .family(dec_family)
  );

  // Counter points past the opcode and all of its operand bytes
  assign pc_after = opc_r + AMD_ADDR_STEP + {14'h0000, nops_r};

  amd_ea_calc u_calc (
    .base(calc_base),
    .index(index_r),
    .add_index(calc_add_idx),
    .next_pc(pc_after),
    .disp(calc_disp),
    .ea(calc_ea),
    .target(calc_target)
  );

  // Base address and displacement by mode
  always_comb begin
    calc_base = amd_page0(b0_r);
    calc_add_idx = 1'b0;
    calc_disp = b0_r;
    unique case (mode_r)
      AMD_INH, AMD_IMM, AMD_REL_D: begin
        calc_base = amd_page0(b0_r);
      end
      AMD_DIR_S, AMD_BIT_D: begin
        calc_base = amd_page0(b0_r);
      end
      AMD_DIR_L: begin
        calc_base = {b0_r, b1_r};
      end
      AMD_IDX_0: begin
        calc_base = AMD_ADDR_RST;
        calc_add_idx = 1'b1;
      end
      AMD_IDX_S: begin
        calc_base = amd_page0(b0_r);
        calc_add_idx = 1'b1;
      end
      AMD_IDX_L: begin
        calc_base = {b0_r, b1_r};
        calc_add_idx = 1'b1;
      end
      AMD_IND_S, AMD_BIT_I: begin
        calc_base = amd_page0(p0_r);
      end
      AMD_IND_L: begin
        calc_base = {p0_r, p1_r};
      end
      AMD_IIDX_S: begin
        calc_base = amd_page0(p0_r);
        calc_add_idx = 1'b1;
      end
      AMD_IIDX_L: begin
        calc_base = {p0_r, p1_r};
        calc_add_idx = 1'b1;
      end
      AMD_REL_I: begin
        calc_disp = p0_r;
      end
      AMD_BTJ_D: begin
        calc_disp = b1_r;
      end
      AMD_BTJ_I: begin
        calc_base = amd_page0(p0_r);
        calc_disp = b1_r;
      end
    endcase
  end

  // Sequencer: one byte per acknowledged read, operand bytes then pointer
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    nops_nxt = nops_r;
    nptr_nxt = nptr_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    opc_nxt = opc_r;
    index_nxt = index_r;
    rmw_nxt = rmw_r;
    long_nxt = long_r;
    ind_nxt = ind_r;
    len_nxt = len_r;
    fam_nxt = fam_r;
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    p0_nxt = p0_r;
    p1_nxt = p1_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          mode_nxt = mode;
          nops_nxt = dec_opnd;
          nptr_nxt = dec_ptr;
          cnt_nxt = AMD_NONE;
          opc_nxt = opc_addr;
          addr_nxt = opc_addr + AMD_ADDR_STEP;
          index_nxt = use_y ? idx_y : idx_x;
          rmw_nxt = rmw;
          long_nxt = dec_long;
          ind_nxt = dec_ind;
          len_nxt = dec_len;
          fam_nxt = dec_family;
          // Inherent and no-offset indexed need no fetch at all
          state_nxt = (dec_opnd == AMD_NONE) ? ST_CALC : ST_OPND;
        end
      end
      ST_OPND: begin
        if (mem_ack) begin
          if (cnt_r == AMD_NONE) begin
            b0_nxt = mem_rdata;
          end else begin
            b1_nxt = mem_rdata;
          end
          cnt_nxt = cnt_r + AMD_ONE;
          addr_nxt = addr_r + AMD_ADDR_STEP;
          if (cnt_r + AMD_ONE == nops_r) begin
            cnt_nxt = AMD_NONE;
            if (ind_r) begin
              // Pointer lives in page zero at the first operand byte
              addr_nxt = amd_page0(cnt_r == AMD_NONE ? mem_rdata : b0_r);
              state_nxt = ST_PTR;
            end else begin
              state_nxt = ST_CALC;
            end
          end
        end
      end
      ST_PTR: begin
        if (mem_ack) begin
          // Word pointers are high byte first
          if (cnt_r == AMD_NONE) begin
            p0_nxt = mem_rdata;
          end else begin
            p1_nxt = mem_rdata;
          end
          cnt_nxt = cnt_r + AMD_ONE;
          addr_nxt = addr_r + AMD_ADDR_STEP;
          if (cnt_r + AMD_ONE == nptr_r) begin
            state_nxt = ST_CALC;
          end
        end
      end
      ST_CALC: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      mode_r <= AMD_INH;
      nops_r <= AMD_NONE;
      nptr_r <= AMD_NONE;
      cnt_r <= AMD_NONE;
      addr_r <= AMD_ADDR_RST;
      opc_r <= AMD_ADDR_RST;
      index_r <= AMD_BYTE_RST;
      rmw_r <= 1'b0;
      long_r <= 1'b0;
      ind_r <= 1'b0;
      len_r <= 3'h0;
      fam_r <= AMD_F_INHERENT;
      b0_r <= AMD_BYTE_RST;
      b1_r <= AMD_BYTE_RST;
      p0_r <= AMD_BYTE_RST;
      p1_r <= AMD_BYTE_RST;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      nops_r <= nops_nxt;
      nptr_r <= nptr_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      opc_r <= opc_nxt;
      index_r <= index_nxt;
      rmw_r <= rmw_nxt;
      long_r <= long_nxt;
      ind_r <= ind_nxt;
      len_r <= len_nxt;
      fam_r <= fam_nxt;
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
      p0_r <= p0_nxt;
      p1_r <= p1_nxt;
    end
  end

  // Results other than done are captured in the calculate step and held until the next one
  always_comb begin
    done_nxt = 1'b0;
    ea_nxt = ea_r;
    ea_valid_nxt = ea_valid_r;
    operand_nxt = operand_r;
    operand_valid_nxt = operand_valid_r;
    target_nxt = target_r;
    target_valid_nxt = target_valid_r;
    next_pc_nxt = next_pc_r;
    instr_len_nxt = instr_len_r;
    family_nxt = family_r;
    short_nxt = short_r;
    rmw_fault_nxt = rmw_fault_r;
    if (state_r == ST_CALC) begin
      done_nxt = 1'b1;
      ea_nxt = calc_ea;
      ea_valid_nxt = (fam_r != AMD_F_INHERENT) && (fam_r != AMD_F_IMMEDIATE)
                     && (fam_r != AMD_F_RELATIVE);
      operand_nxt = b0_r;
      operand_valid_nxt = (fam_r == AMD_F_IMMEDIATE);
      target_nxt = calc_target;
      target_valid_nxt = (fam_r == AMD_F_RELATIVE)
                         || (mode_r == AMD_BTJ_D) || (mode_r == AMD_BTJ_I);
      next_pc_nxt = pc_after;
      instr_len_nxt = len_r;
      family_nxt = fam_r;
      short_nxt = !long_r;
      // Read-modify-write operations have no long encoding
      rmw_fault_nxt = rmw_r && long_r;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
      ea_r <= AMD_ADDR_RST;
      ea_valid_r <= 1'b0;
      operand_r <= AMD_BYTE_RST;
      operand_valid_r <= 1'b0;
      target_r <= AMD_ADDR_RST;
      target_valid_r <= 1'b0;
      next_pc_r <= AMD_ADDR_RST;
      instr_len_r <= 3'h0;
      family_r <= AMD_F_INHERENT;
      short_r <= 1'b0;
      rmw_fault_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      ea_r <= ea_nxt;
      ea_valid_r <= ea_valid_nxt;
      operand_r <= operand_nxt;
      operand_valid_r <= operand_valid_nxt;
      target_r <= target_nxt;
      target_valid_r <= target_valid_nxt;
      next_pc_r <= next_pc_nxt;
      instr_len_r <= instr_len_nxt;
      family_r <= family_nxt;
      short_r <= short_nxt;
      rmw_fault_r <= rmw_fault_nxt;
    end
  end

  // Read request is a level held until acknowledged
  assign mem_req = (state_r == ST_OPND) || (state_r == ST_PTR);
  assign mem_addr = addr_r;
  assign busy = (state_r != ST_IDLE);
  assign done = done_r;
  assign ea = ea_r;
  assign ea_valid = ea_valid_r;
  assign operand = operand_r;
  assign operand_valid = operand_valid_r;
  assign target = target_r;
  assign target_valid = target_valid_r;
  assign next_pc = next_pc_r;
  assign instr_len = instr_len_r;
  assign family = family_r;
  assign short_form = short_r;
  assign rmw_fault = rmw_fault_r;

endmodule

// ==== amd_decoder_checker.sv ====
// Concurrent checks on the address mode decoder ports
module amd_decoder_checker
  import amd_pkg::*;
(
  input logic clock,
  input logic nrst,
  input logic start,
  input amd_mode_t mode,
  input logic use_y,
  input logic rmw,
  input logic [15:0] opc_addr,
  input logic mem_req,
  input logic [15:0] mem_addr,
  input logic mem_ack,
  input logic busy,
  input logic done,
  input logic [15:0] ea,
  input logic [15:0] target,
  input logic target_valid,
  input logic [15:0] next_pc,
  input logic [2:0] instr_len,
  input logic short_form,
  input logic rmw_fault
);
  amd_mode_t mode_c;
  logic y_c;
  logic rmw_c;
  logic [15:0] opc_c;
  logic pre_c;
  logic long_c;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Operand bytes after the opcode, prebyte excluded
  function automatic logic [2:0] opnd_n(input amd_mode_t m);
    case (m)
      AMD_INH, AMD_IDX_0: opnd_n = 3'h0;
      AMD_DIR_L, AMD_IDX_L, AMD_BTJ_D, AMD_BTJ_I: opnd_n = 3'h2;
      default: opnd_n = 3'h1;
    endcase
  endfunction

  // Request copy, since inputs may move once taken
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_c <= AMD_INH;
      y_c <= 1'b0;
      rmw_c <= 1'b0;
      opc_c <= 16'h0000;
    end else if (start && !busy) begin
      mode_c <= mode;
      y_c <= use_y;
      rmw_c <= rmw;
      opc_c <= opc_addr;
    end
  end

  assign pre_c = y_c || (mode_c inside {AMD_IND_S, AMD_IND_L, AMD_IIDX_S, AMD_IIDX_L,
    AMD_REL_I, AMD_BIT_I, AMD_BTJ_I});
  assign long_c = mode_c inside {AMD_DIR_L, AMD_IDX_L, AMD_IND_L, AMD_IIDX_L};

  a_len_rule: assert property (done |-> instr_len == 3'h1 + opnd_n(mode_c) + {2'h0, pre_c})
    else $error("instruction length wrong for mode");
  a_next_pc: assert property (done |-> next_pc == opc_c + 16'h0001 + {13'h0, opnd_n(mode_c)})
    else $error("next pc does not skip operand bytes");
  a_target_span: assert property (done && target_valid |-> 16'(target - next_pc + 16'h0080) < 16'h0100)
    else $error("branch target out of span");
  a_short_flag: assert property (done |-> short_form == !long_c)
    else $error("short form flag wrong");
  a_rmw_long: assert property (done |-> rmw_fault == (rmw_c && long_c))
    else $error("rmw fault flag wrong");
  a_page_zero: assert property (done && (mode_c inside {AMD_DIR_S, AMD_IND_S, AMD_BIT_D,
    AMD_BIT_I, AMD_BTJ_D, AMD_BTJ_I}) |-> ea[15:8] == 8'h00)
    else $error("short address left page zero");
  a_ack_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch dropped before ack");
  a_first_fetch: assert property (start && !busy && (mode inside {AMD_IMM, AMD_DIR_S, AMD_DIR_L,
    AMD_REL_D}) |=> mem_req && mem_addr == $past(opc_addr) + 16'h0001)
    else $error("first fetch not after opcode");
  a_inh_fast: assert property (start && !busy && mode == AMD_INH |-> ##2 done)
    else $error("inherent request not done in two cycles");
  a_done_bound: assert property (start && !busy |-> ##[2:60] done)
    else $error("request never completed");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
endmodule

bind amd_decoder amd_decoder_checker chk_u (.clock(clock), .nrst(nrst), .start(start),
  .mode(mode), .use_y(use_y), .rmw(rmw), .opc_addr(opc_addr), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_ack(mem_ack), .busy(busy), .done(done), .ea(ea), .target(target),
  .target_valid(target_valid), .next_pc(next_pc), .instr_len(instr_len),
  .short_form(short_form), .rmw_fault(rmw_fault));

// ==== amd_ea_calc.sv ====
// Effective address adder and relative branch target adder
module amd_ea_calc
  import amd_pkg::*;
(
  input logic [15:0] base,
  input logic [7:0] index,
  input logic add_index,
  input logic [15:0] next_pc,
  input logic [7:0] disp,
  output logic [15:0] ea,
  output logic [15:0] target
);

  // Unsigned sum, carry into the high byte is kept
  assign ea = base + (add_index ? {8'h00, index} : 16'h0000);
  // Wraps at the top of the space, as the counter does
  assign target = next_pc + amd_sext(disp);

endmodule

// ==== amd_len_dec.sv ====
// Instruction length and fetch shape decoding per addressing mode
module amd_len_dec
  import amd_pkg::*;
(
  input amd_mode_t mode,
  input logic use_y,
  output logic [1:0] opnd_bytes,
  output logic [1:0] ptr_bytes,
  output logic pre_byte,
  output logic [2:0] instr_len,
  output logic indirect,
  output logic long_form,
  output amd_family_t family
);

  always_comb begin
    opnd_bytes = AMD_NONE;
    ptr_bytes = AMD_NONE;
    long_form = 1'b0;
    family = AMD_F_INHERENT;
    unique case (mode)
      AMD_INH: begin
        family = AMD_F_INHERENT;
      end
      AMD_IMM: begin
        opnd_bytes = AMD_ONE;
        family = AMD_F_IMMEDIATE;
      end
      AMD_DIR_S: begin
        opnd_bytes = AMD_ONE;
        family = AMD_F_DIRECT;
      end
      AMD_DIR_L: begin
        opnd_bytes = AMD_TWO;
        long_form = 1'b1;
        family = AMD_F_DIRECT;
      end
      AMD_IDX_0: begin
        family = AMD_F_INDEXED;
      end
      AMD_IDX_S: begin
        opnd_bytes = AMD_ONE;
        family = AMD_F_INDEXED;
      end
      AMD_IDX_L: begin
        opnd_bytes = AMD_TWO;
        long_form = 1'b1;
        family = AMD_F_INDEXED;
      end
      AMD_IND_S, AMD_IIDX_S: begin
        opnd_bytes = AMD_ONE;
        ptr_bytes = AMD_ONE;
        family = AMD_F_INDIRECT;
      end
      AMD_IND_L, AMD_IIDX_L: begin
        opnd_bytes = AMD_ONE;
        ptr_bytes = AMD_TWO;
        long_form = 1'b1;
        family = AMD_F_INDIRECT;
      end
      AMD_REL_D: begin
        opnd_bytes = AMD_ONE;
        family = AMD_F_RELATIVE;
      end
      AMD_REL_I: begin
        opnd_bytes = AMD_ONE;
        ptr_bytes = AMD_ONE;
        family = AMD_F_RELATIVE;
      end
      AMD_BIT_D: begin
        opnd_bytes = AMD_ONE;
        family = AMD_F_BIT;
      end
      AMD_BIT_I: begin
        opnd_bytes = AMD_ONE;
        ptr_bytes = AMD_ONE;
        family = AMD_F_BIT;
      end
      AMD_BTJ_D: begin
        opnd_bytes = AMD_TWO;
        family = AMD_F_BIT;
      end
      AMD_BTJ_I: begin
        opnd_bytes = AMD_TWO;
        ptr_bytes = AMD_ONE;
        family = AMD_F_BIT;
      end
    endcase
  end

  // Indirect forms ride on a prebyte; so does Y on non-indirect forms
  assign indirect = (ptr_bytes != AMD_NONE);
  assign pre_byte = indirect | use_y;
  assign instr_len = 3'(1) + {2'b00, pre_byte} + {1'b0, opnd_bytes};

endmodule

// ==== amd_mem_model.sv ====
// Program and data memory partner with prompt or slow acknowledge
module amd_mem_model (
  input logic clock,
  input logic nrst,
  input logic slow,
  input logic mem_req,
  input logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [1:0] wait_r;
  // Slow mode holds ack off for two cycles per byte
  assign mem_ack = mem_req && (!slow || wait_r == 2'h2);
  // Inverted data off ack exposes sampling at the wrong cycle
  assign mem_rdata = mem_ack ? mem[mem_addr] : ~mem[mem_addr];
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      wait_r <= 2'h0;
    else if (!mem_req || mem_ack)
      wait_r <= 2'h0;
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule

// ==== amd_pkg.sv ====
// Shared constants, mode codes and helpers for the address mode decoder
package amd_pkg;

  localparam int AMD_AW = 16;
  localparam int AMD_DW = 8;
  localparam int AMD_LEN_W = 3;
  localparam int AMD_CNT_W = 2;

  // Upper address byte of page zero
  localparam logic [7:0] AMD_PAGE0_HI = 8'h00;
  // Reset values
  localparam logic [15:0] AMD_ADDR_RST = 16'h0000;
  localparam logic [7:0] AMD_BYTE_RST = 8'h00;

  // Byte counts
  localparam logic [1:0] AMD_NONE = 2'h0;
  localparam logic [1:0] AMD_ONE = 2'h1;
  localparam logic [1:0] AMD_TWO = 2'h2;
  localparam logic [15:0] AMD_ADDR_STEP = 16'h0001;

  typedef enum logic [4:0] {
    AMD_INH, AMD_IMM, AMD_DIR_S, AMD_DIR_L, AMD_IDX_0, AMD_IDX_S, AMD_IDX_L,
    AMD_IND_S, AMD_IND_L, AMD_IIDX_S, AMD_IIDX_L, AMD_REL_D, AMD_REL_I,
    AMD_BIT_D, AMD_BIT_I, AMD_BTJ_D, AMD_BTJ_I
  } amd_mode_t;

  typedef enum logic [2:0] {
    AMD_F_INHERENT, AMD_F_IMMEDIATE, AMD_F_DIRECT, AMD_F_INDEXED,
    AMD_F_INDIRECT, AMD_F_RELATIVE, AMD_F_BIT
  } amd_family_t;

  // Sign extension of an 8-bit displacement to the address width
  function automatic logic [15:0] amd_sext(input logic [7:0] d);
    amd_sext = {{8{d[7]}}, d};
  endfunction

  // Page-zero address from one byte
  function automatic logic [15:0] amd_page0(input logic [7:0] b);
    amd_page0 = {AMD_PAGE0_HI, b};
  endfunction

endpackage

// ==== test_cpu_address_mode_decoder.sv ====
// Self-checking bench for the address mode decoder
`define CK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module test_cpu_address_mode_decoder
  import amd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, start, use_y, rmw, slow, mem_req, mem_ack, busy, done;
  logic ea_valid, operand_valid, target_valid, short_form, rmw_fault;
  amd_mode_t mode;
  amd_family_t family;
  logic [15:0] opc_addr, mem_addr, ea, target, next_pc;
  logic [7:0] idx_x, idx_y, mem_rdata, operand;
  logic [2:0] instr_len;
  int n_errors, samples_checked, cycles;

  amd_decoder dut_u (.clock(clock), .nrst(nrst), .start(start), .mode(mode), .use_y(use_y),
    .rmw(rmw), .opc_addr(opc_addr), .idx_x(idx_x), .idx_y(idx_y), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .done(done),
    .ea(ea), .ea_valid(ea_valid), .operand(operand), .operand_valid(operand_valid),
    .target(target), .target_valid(target_valid), .next_pc(next_pc), .instr_len(instr_len),
    .family(family), .short_form(short_form), .rmw_fault(rmw_fault));
  amd_mem_model mem_u (.clock(clock), .nrst(nrst), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  task automatic end_sim;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One request; poke retries start while busy, which must be ignored
  task automatic go(input amd_mode_t m, input logic y, input logic r, input logic [15:0] opc,
    input logic [7:0] x, input logic [7:0] yv, input logic poke);
    int i;
    @(posedge clock);
    start <= 1'b1;
    mode <= m;
    use_y <= y;
    rmw <= r;
    opc_addr <= opc;
    idx_x <= x;
    idx_y <= yv;
    @(posedge clock);
    start <= 1'b0;
    if (poke) begin
      @(posedge clock);
      start <= 1'b1;
      mode <= AMD_INH;
      @(posedge clock);
      start <= 1'b0;
    end
    @(negedge clock);
    `CK(busy, 1'b1)
    for (i = 0; i < 60; i++) begin
      @(negedge clock);
      if (done === 1'b1)
        break;
    end
    `CK(done, 1'b1)
    `CK(busy, 1'b0)
  endtask

  task automatic s_inherent;
    go(AMD_INH, 1'b0, 1'b0, 16'h0200, 8'h00, 8'h00, 1'b0);
    `CK(instr_len, 3'h1)
    `CK(next_pc, 16'h0201)
    `CK(ea_valid, 1'b0)
    go(AMD_INH, 1'b1, 1'b0, 16'h0200, 8'h00, 8'h00, 1'b0);
    `CK(instr_len, 3'h2)
  endtask

  task automatic s_immediate;
    mem_u.mem[16'h0301] = 8'ha5;
    go(AMD_IMM, 1'b0, 1'b0, 16'h0300, 8'h00, 8'h00, 1'b0);
    `CK(operand, 8'ha5)
    `CK(operand_valid, 1'b1)
    `CK(instr_len, 3'h2)
  endtask

  task automatic s_direct;
    mem_u.mem[16'h0401] = 8'hff;
    mem_u.mem[16'h0501] = 8'hab;
    mem_u.mem[16'h0502] = 8'hcd;
    go(AMD_DIR_S, 1'b0, 1'b1, 16'h0400, 8'h00, 8'h00, 1'b0);
    `CK(ea, 16'h00ff)
    `CK(ea_valid, 1'b1)
    `CK(short_form, 1'b1)
    `CK(rmw_fault, 1'b0)
    go(AMD_DIR_L, 1'b0, 1'b1, 16'h0500, 8'h00, 8'h00, 1'b0);
    `CK(ea, 16'habcd)
    `CK(instr_len, 3'h3)
    `CK(rmw_fault, 1'b1)
    `CK(next_pc, 16'h0503)
  endtask

  task automatic s_indexed;
    mem_u.mem[16'h0701] = 8'hff;
    mem_u.mem[16'h0801] = 8'hff;
    mem_u.mem[16'h0802] = 8'h00;
    go(AMD_IDX_0, 1'b0, 1'b0, 16'h0600, 8'hff, 8'h00, 1'b0);
    `CK(ea, 16'h00ff)
    `CK(instr_len, 3'h1)
    go(AMD_IDX_0, 1'b1, 1'b0, 16'h0600, 8'h00, 8'h80, 1'b0);
    `CK(ea, 16'h0080)
    `CK(instr_len, 3'h2)
    go(AMD_IDX_S, 1'b0, 1'b0, 16'h0700, 8'hff, 8'h00, 1'b0);
    `CK(ea, 16'h01fe)
    go(AMD_IDX_L, 1'b1, 1'b0, 16'h0800, 8'h00, 8'hff, 1'b0);
    `CK(ea, 16'hffff)
    `CK(instr_len, 3'h4)
  endtask

  task automatic s_indirect;
    mem_u.mem[16'h0901] = 8'hff;
    // Pointer differs from its own address so a skipped fetch shows
    mem_u.mem[16'h00ff] = 8'hc7;
    mem_u.mem[16'h0100] = 8'h34;
    go(AMD_IND_S, 1'b0, 1'b0, 16'h0900, 8'h00, 8'h00, 1'b0);
    `CK(ea, 16'h00c7)
    `CK(instr_len, 3'h3)
    @(posedge clock);
    slow <= 1'b1;
    go(AMD_IND_L, 1'b0, 1'b0, 16'h0900, 8'h00, 8'h00, 1'b1);
    `CK(ea, 16'hc734)
    `CK(short_form, 1'b0)
    slow <= 1'b0;
    go(AMD_IIDX_S, 1'b0, 1'b0, 16'h0900, 8'hff, 8'h00, 1'b0);
    `CK(ea, 16'h01c6)
    go(AMD_IIDX_L, 1'b1, 1'b0, 16'h0900, 8'h00, 8'h10, 1'b0);
    `CK(ea, 16'hc744)
    `CK(instr_len, 3'h3)
  endtask

  task automatic s_relative;
    mem_u.mem[16'h0a01] = 8'h80;
    mem_u.mem[16'h0b01] = 8'h7f;
    mem_u.mem[16'h0c01] = 8'h40;
    mem_u.mem[16'h0040] = 8'hfe;
    go(AMD_REL_D, 1'b0, 1'b0, 16'h0a00, 8'h00, 8'h00, 1'b0);
    `CK(target, 16'h0982)
    `CK(target_valid, 1'b1)
    go(AMD_REL_D, 1'b0, 1'b0, 16'h0b00, 8'h00, 8'h00, 1'b0);
    `CK(target, 16'h0b81)
    go(AMD_REL_I, 1'b0, 1'b0, 16'h0c00, 8'h00, 8'h00, 1'b0);
    `CK(target, 16'h0c00)
    `CK(instr_len, 3'h3)
  endtask

  task automatic s_bit;
    mem_u.mem[16'h0d01] = 8'h20;
    mem_u.mem[16'h0d02] = 8'h05;
    mem_u.mem[16'h0020] = 8'h33;
    go(AMD_BIT_D, 1'b0, 1'b0, 16'h0d00, 8'h00, 8'h00, 1'b0);
    `CK(ea, 16'h0020)
    go(AMD_BIT_I, 1'b0, 1'b0, 16'h0d00, 8'h00, 8'h00, 1'b0);
    `CK(ea, 16'h0033)
    go(AMD_BTJ_D, 1'b0, 1'b0, 16'h0d00, 8'h00, 8'h00, 1'b0);
    `CK(target, 16'h0d08)
    `CK(instr_len, 3'h3)
    go(AMD_BTJ_I, 1'b0, 1'b0, 16'h0d00, 8'h00, 8'h00, 1'b0);
    `CK(ea, 16'h0033)
    `CK(target, 16'h0d08)
    `CK(instr_len, 3'h4)
  endtask

  task automatic s_family;
    amd_family_t f [17];
    f = '{AMD_F_INHERENT, AMD_F_IMMEDIATE, AMD_F_DIRECT, AMD_F_DIRECT, AMD_F_INDEXED,
      AMD_F_INDEXED, AMD_F_INDEXED, AMD_F_INDIRECT, AMD_F_INDIRECT, AMD_F_INDIRECT,
      AMD_F_INDIRECT, AMD_F_RELATIVE, AMD_F_RELATIVE, AMD_F_BIT, AMD_F_BIT, AMD_F_BIT, AMD_F_BIT};
    mem_u.mem[16'h0a02] = 8'h00;
    mem_u.mem[16'h0080] = 8'h00;
    mem_u.mem[16'h0081] = 8'h00;
    for (int i = 0; i < 17; i++) begin
      go(amd_mode_t'(i), 1'b0, 1'b0, 16'h0a00, 8'h00, 8'h00, 1'b0);
      `CK(family, f[i])
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard well above the few hundred cycles needed
  initial begin
    cycles = 0;
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles == 20000) begin
        n_errors++;
        end_sim();
      end
    end
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    nrst = 1'b0;
    start = 1'b0;
    mode = AMD_INH;
    use_y = 1'b0;
    rmw = 1'b0;
    slow = 1'b0;
    opc_addr = 16'h0000;
    idx_x = 8'h00;
    idx_y = 8'h00;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    s_inherent();
    s_immediate();
    s_direct();
    s_indexed();
    s_indirect();
    s_relative();
    s_bit();
    s_family();
    end_sim();
  end
endmodule
